// >>> design/clrwd_pkg.sv
// Constants and carrier types shared by the clear-file / clear-watchdog unit.
// Assumes a single 100 MHz core clock and a four-phase instruction cycle.
package clrwd_pkg;
   // Opcode patterns and access bit position
   localparam logic [15:0] OPC_FILE_MASK = 16'hFE00;
   localparam logic [15:0] OPC_FILE_VAL = 16'h6A00;
   localparam logic [15:0] OPC_WDT_VAL = 16'h0004;
   localparam int ACC_BIT_POS = 8;
   // Register offsets on the software port
   localparam logic [7:0] OFS_BANK_SEL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_WDT = 8'h08;
   // Status field positions
   localparam int ST_ZERO_POS = 0;
   localparam int ST_TO_POS = 1;
   localparam int ST_PD_POS = 2;
   // Reset values and fixed access bank
   localparam logic [3:0] BANK_SEL_RST = 4'h0;
   localparam logic FLAG_RST = 1'b1;
   localparam logic ZERO_RST = 1'b0;
   localparam logic [3:0] ACCESS_BANK = 4'h0;

   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } clrwd_phase_e;

   typedef enum logic [2:0] {
      OP_NONE = 3'h1,
      OP_FILE = 3'h2,
      OP_WDT = 3'h4
   } clrwd_op_e;

   typedef struct packed {
      logic [11:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } clrwd_file_s;
endpackage

// >>> design/clrwd_core.sv
// Execution unit for the clear-file and clear-watchdog instructions.
// Assumes opcode words arrive synchronous to clock_in, sampled in phase Q1.
// Notes on behaviour
// - Clear-file writes zero to the target register and sets only zero flag.
// - Access bit zero selects the access bank, ignoring bank select.
// - Access bit one forms address from bank select and 8-bit field.
// - Clear-file: decode Q1, read Q2, process Q3, write Q4, one cycle.
// - Clear-watchdog opcode resets the watchdog counter to zero.
// - Clear-watchdog also clears postscaler and sets timeout and powerdown flags.
`timescale 1ns/10ps
module clrwd_core #(
   parameter int WDT_W = 8,
   parameter int POST_W = 7
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Instruction stream
   input wire logic instr_valid_in,
   input wire logic [15:0] opcode_in,
   // Watchdog time base
   input wire logic wdt_tick_in,
   // File memory port
   output clrwd_pkg::clrwd_file_s file_out,
   input wire logic [7:0] file_rdata_in,
   // Status flags and current phase
   output logic zero_flag_out,
   output logic timeout_flag_out,
   output logic powerdown_flag_out,
   output logic [1:0] phase_out,
   // Software register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out
);
   clrwd_pkg::clrwd_phase_e phase_reg, phase_next;
   clrwd_pkg::clrwd_op_e op_reg, op_next;
   clrwd_pkg::clrwd_file_s file_reg, file_next;
   logic [11:0] target_reg, target_next;
   logic acc_reg, acc_next;
   logic [3:0] bank_select_reg, bank_select_next;
   logic zero_reg, zero_next;
   logic timeout_flag_reg, timeout_flag_next;
   logic powerdown_flag_reg, powerdown_flag_next;
   logic [WDT_W-1:0] watchdog_counter_reg, watchdog_counter_next;
   logic [POST_W-1:0] post_reg, post_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [7:0] file_data_reg, file_data_next;
   logic dec_file, dec_wdt;

   function automatic logic is_file_op(input logic [15:0] w);
      return (w & clrwd_pkg::OPC_FILE_MASK) == clrwd_pkg::OPC_FILE_VAL;
   endfunction

   assign dec_file = instr_valid_in && is_file_op(opcode_in);
   assign dec_wdt = instr_valid_in && (opcode_in == clrwd_pkg::OPC_WDT_VAL);

   // Sequencer and decode
   always_comb begin
      phase_next = phase_reg;
      op_next = op_reg;
      target_next = target_reg;
      acc_next = acc_reg;
      unique case (phase_reg)
         clrwd_pkg::PH_Q1: begin
            phase_next = clrwd_pkg::PH_Q2;
            acc_next = opcode_in[clrwd_pkg::ACC_BIT_POS];
            if (opcode_in[clrwd_pkg::ACC_BIT_POS]) begin
               target_next = {bank_select_reg, opcode_in[7:0]};
            end else begin
               target_next = {clrwd_pkg::ACCESS_BANK, opcode_in[7:0]};
            end
            if (dec_file) begin
               op_next = clrwd_pkg::OP_FILE;
            end else if (dec_wdt) begin
               op_next = clrwd_pkg::OP_WDT;
            end else begin
               op_next = clrwd_pkg::OP_NONE;
            end
         end
         clrwd_pkg::PH_Q2: phase_next = clrwd_pkg::PH_Q3;
         clrwd_pkg::PH_Q3: phase_next = clrwd_pkg::PH_Q4;
         clrwd_pkg::PH_Q4: phase_next = clrwd_pkg::PH_Q1;
         default: phase_next = clrwd_pkg::PH_Q1;
      endcase
   end

   // File port: strobes registered one cycle ahead so they stand in Q2 and Q4
   always_comb begin
      file_next = '0;
      file_data_next = file_data_reg;
      file_next.addr = target_reg;
      if (phase_reg == clrwd_pkg::PH_Q1 && dec_file) begin
         file_next.rd = 1'b1;
         file_next.addr = target_next;
      end
      // Process step: value read is captured but the result is always zero
      if (phase_reg == clrwd_pkg::PH_Q2 && op_reg == clrwd_pkg::OP_FILE) begin
         file_data_next = file_rdata_in;
      end
      if (phase_reg == clrwd_pkg::PH_Q3 && op_reg == clrwd_pkg::OP_FILE) begin
         file_next.wr = 1'b1;
         file_next.wdata = 8'h00;
      end
   end

   // Flags, watchdog and software registers
   always_comb begin
      bank_select_next = bank_select_reg;
      zero_next = zero_reg;
      timeout_flag_next = timeout_flag_reg;
      powerdown_flag_next = powerdown_flag_reg;
      watchdog_counter_next = watchdog_counter_reg;
      post_next = post_reg;
      rdata_next = 32'h0000_0000;
      if (wdt_tick_in) begin
         post_next = post_reg + POST_W'(1);
         if (post_reg == '1) begin
            watchdog_counter_next = watchdog_counter_reg + WDT_W'(1);
         end
      end
      if (reg_wr_in && reg_addr_in == clrwd_pkg::OFS_BANK_SEL) begin
         bank_select_next = reg_wdata_in[3:0];
      end
      if (reg_wr_in && reg_addr_in == clrwd_pkg::OFS_STATUS) begin
         zero_next = reg_wdata_in[clrwd_pkg::ST_ZERO_POS];
         timeout_flag_next = reg_wdata_in[clrwd_pkg::ST_TO_POS];
         powerdown_flag_next = reg_wdata_in[clrwd_pkg::ST_PD_POS];
      end
      if (phase_reg == clrwd_pkg::PH_Q4 && op_reg == clrwd_pkg::OP_FILE) begin
         zero_next = 1'b1;
      end
      if (phase_reg == clrwd_pkg::PH_Q3 && op_reg == clrwd_pkg::OP_WDT) begin
         watchdog_counter_next = '0;
         post_next = '0;
         timeout_flag_next = 1'b1;
         powerdown_flag_next = 1'b1;
      end
      if (reg_rd_in) begin
         unique case (reg_addr_in)
            clrwd_pkg::OFS_BANK_SEL: rdata_next = {28'h000_0000, bank_select_reg};
            clrwd_pkg::OFS_STATUS: rdata_next = {29'h0000_0000, powerdown_flag_reg,
                                                 timeout_flag_reg, zero_reg};
            clrwd_pkg::OFS_WDT: rdata_next = {{(32 - POST_W - WDT_W){1'b0}}, post_reg,
                                              watchdog_counter_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase_reg <= clrwd_pkg::PH_Q1;
         op_reg <= clrwd_pkg::OP_NONE;
         target_reg <= 12'h000;
         acc_reg <= 1'b1;
         file_reg <= '0;
         file_data_reg <= 8'h00;
         bank_select_reg <= clrwd_pkg::BANK_SEL_RST;
         zero_reg <= clrwd_pkg::ZERO_RST;
         timeout_flag_reg <= clrwd_pkg::FLAG_RST;
         powerdown_flag_reg <= clrwd_pkg::FLAG_RST;
         watchdog_counter_reg <= '0;
         post_reg <= '0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         phase_reg <= phase_next;
         op_reg <= op_next;
         target_reg <= target_next;
         acc_reg <= acc_next;
         file_reg <= file_next;
         file_data_reg <= file_data_next;
         bank_select_reg <= bank_select_next;
         zero_reg <= zero_next;
         timeout_flag_reg <= timeout_flag_next;
         powerdown_flag_reg <= powerdown_flag_next;
         watchdog_counter_reg <= watchdog_counter_next;
         post_reg <= post_next;
         rdata_reg <= rdata_next;
      end
   end

   assign file_out = file_reg;
   assign zero_flag_out = zero_reg;
   assign timeout_flag_out = timeout_flag_reg;
   assign powerdown_flag_out = powerdown_flag_reg;
   assign reg_rdata_out = rdata_reg;
   always_comb begin
      unique case (phase_reg)
         clrwd_pkg::PH_Q1: phase_out = 2'h0;
         clrwd_pkg::PH_Q2: phase_out = 2'h1;
         clrwd_pkg::PH_Q3: phase_out = 2'h2;
         clrwd_pkg::PH_Q4: phase_out = 2'h3;
         default: phase_out = 2'h0;
      endcase
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);

   sequence file_decode_s;
      phase_reg == clrwd_pkg::PH_Q1 && dec_file;
   endsequence
   sequence file_steps_s;
      file_out.rd ##1 (!file_out.rd && !file_out.wr) ##1 (file_out.wr && file_out.wdata == 8'h00);
   endsequence

   file_phases_a: assert property (file_decode_s |=> file_steps_s)
      else $error("clear-file phase order wrong");
   zero_set_a: assert property (file_decode_s |-> ##4 zero_flag_out)
      else $error("zero flag not set after clear-file");
   // A software status write one cycle earlier may legally move the flags
   file_status_a: assert property (
      (file_decode_s and !(phase_reg == clrwd_pkg::PH_Q1 && reg_wr_in))
      |-> ##4 ($past(reg_wr_in) || ($stable(timeout_flag_out) && $stable(powerdown_flag_out))))
      else $error("clear-file changed other status");
   access_bank_a: assert property (
      (file_decode_s and !opcode_in[clrwd_pkg::ACC_BIT_POS])
      |=> file_out.addr == {clrwd_pkg::ACCESS_BANK, $past(opcode_in[7:0])})
      else $error("access bank not used");
   banked_addr_a: assert property (
      (file_decode_s and opcode_in[clrwd_pkg::ACC_BIT_POS])
      |=> file_out.addr == {$past(bank_select_reg), $past(opcode_in[7:0])})
      else $error("bank select not used");
   wdt_clear_a: assert property (
      phase_reg == clrwd_pkg::PH_Q1 && dec_wdt
      |-> ##3 watchdog_counter_reg == '0 && post_reg == '0)
      else $error("watchdog not cleared");
   wdt_flags_a: assert property (
      phase_reg == clrwd_pkg::PH_Q1 && dec_wdt
      |-> ##3 timeout_flag_out && powerdown_flag_out)
      else $error("timeout or powerdown flag not set");
   wdt_quiet_a: assert property (
      phase_reg == clrwd_pkg::PH_Q1 && dec_wdt
      |=> (!file_out.rd && !file_out.wr)[*4])
      else $error("clear-watchdog touched file port");
endmodule

// >>> tb/tb_clear_file_and_watchdog_ops.sv
// Self-checking bench for the clear-file / clear-watchdog execution unit.
// Assumes clrwd_pkg is compiled first; the bench plays core and software port.
`timescale 1ns/10ps
module tb_clear_file_and_watchdog_ops;
   logic clock_in, rst_b_in, instr_valid_in, wdt_tick_in, reg_wr_in, reg_rd_in;
   logic [15:0] opcode_in;
   logic [7:0] file_rdata_in, reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out, rd_val;
   logic zero_flag_out, timeout_flag_out, powerdown_flag_out;
   logic [1:0] phase_out;
   clrwd_pkg::clrwd_file_s file_out;
   int miscompares, n_checks;

   clrwd_core #(.WDT_W(8), .POST_W(7)) dut (
      .clock_in(clock_in), .rst_b_in(rst_b_in),
      .instr_valid_in(instr_valid_in), .opcode_in(opcode_in),
      .wdt_tick_in(wdt_tick_in), .file_out(file_out), .file_rdata_in(file_rdata_in),
      .zero_flag_out(zero_flag_out), .timeout_flag_out(timeout_flag_out),
      .powerdown_flag_out(powerdown_flag_out), .phase_out(phase_out),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out)
   );

   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   task automatic conclude();
      $display("checks=%0d miscompares=%0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
      @(posedge clock_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= addr;
      reg_wdata_in <= data;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe, so sample it there
   task automatic reg_read(input logic [7:0] addr, output logic [31:0] data);
      @(posedge clock_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= addr;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      @(negedge clock_in);
      data = reg_rdata_out;
   endtask

   function automatic logic [31:0] flags();
      return {29'h0, powerdown_flag_out, timeout_flag_out, zero_flag_out};
   endfunction

   // Raise the opcode at the edge entering Q1 so it stands through Q1 and is taken at the Q1-to-Q2 edge
   task automatic issue(input logic [15:0] op);
      int i;
      for (i = 0; i < 20; i++) begin
         @(negedge clock_in);
         if (phase_out === 2'h3) break;
      end
      if (i == 20) begin
         miscompares++;
         conclude();
      end
      @(posedge clock_in);
      instr_valid_in <= 1'b1;
      opcode_in <= op;
      @(posedge clock_in);
      instr_valid_in <= 1'b0;
   endtask

   task automatic file_op(input logic [15:0] op, input logic [11:0] addr);
      issue(op);
      @(negedge clock_in);
      check({30'h0, file_out.rd, file_out.wr}, 32'h2);
      check({20'h0, file_out.addr}, {20'h0, addr});
      @(negedge clock_in);
      check({30'h0, file_out.rd, file_out.wr}, 32'h0);
      @(negedge clock_in);
      check({22'h0, file_out.wr, file_out.wdata, file_out.rd}, 32'h200);
      check({20'h0, file_out.addr}, {20'h0, addr});
      check(flags(), 32'h0);
      @(negedge clock_in);
      check(flags(), 32'h1);
   endtask

   initial begin
      rst_b_in = 1'b0;
      instr_valid_in = 1'b0;
      opcode_in = 16'h0000;
      wdt_tick_in = 1'b0;
      file_rdata_in = 8'h5A;
      reg_addr_in = 8'h00;
      reg_wdata_in = 32'h0;
      reg_wr_in = 1'b0;
      reg_rd_in = 1'b0;
      repeat (20) @(posedge clock_in);
      rst_b_in <= 1'b1;
      reg_read(clrwd_pkg::OFS_STATUS, rd_val);
      check(rd_val, 32'h6);
      check({10'h0, file_out}, 32'h0);
      reg_write(clrwd_pkg::OFS_BANK_SEL, 32'hA);
      reg_read(clrwd_pkg::OFS_BANK_SEL, rd_val);
      check(rd_val, 32'hA);
      reg_read(8'h10, rd_val);
      check(rd_val, 32'h0);
      reg_write(clrwd_pkg::OFS_STATUS, 32'h0);
      file_op(16'h6B12, 12'hA12);
      reg_write(clrwd_pkg::OFS_STATUS, 32'h0);
      file_op(16'h6A34, 12'h034);
      reg_write(clrwd_pkg::OFS_STATUS, 32'h0);
      file_op(16'h6BFF, 12'hAFF);
      // A neighbouring opcode must leave flags and file port alone
      reg_write(clrwd_pkg::OFS_STATUS, 32'h0);
      issue(16'h6C12);
      repeat (4) begin
         @(negedge clock_in);
         check({30'h0, file_out.rd, file_out.wr}, 32'h0);
      end
      check(flags(), 32'h0);
      // Enough ticks to wrap the postscaler once, so the counter is non-zero
      repeat (131) begin
         @(posedge clock_in);
         wdt_tick_in <= 1'b1;
         @(posedge clock_in);
         wdt_tick_in <= 1'b0;
      end
      reg_read(clrwd_pkg::OFS_WDT, rd_val);
      check(rd_val, 32'h301);
      issue(clrwd_pkg::OPC_WDT_VAL);
      repeat (2) @(negedge clock_in);
      check(flags(), 32'h0);
      @(negedge clock_in);
      check(flags(), 32'h6);
      reg_read(clrwd_pkg::OFS_WDT, rd_val);
      check(rd_val, 32'h0);
      conclude();
   end

   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule
